// ### src/fbs_pkg.sv
package fbs_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_ALERT_THIRD = 8'h00;
  localparam logic [7:0] OFF_STATUS_THIRD = 8'h04;
  localparam logic [7:0] OFF_ALERT_FOURTH = 8'h08;
  localparam logic [7:0] OFF_STATUS_FOURTH = 8'h0C;
  localparam logic [7:0] OFF_BATTERY = 8'h10;
  localparam logic [7:0] OFF_CONFIG = 8'h14;
  localparam logic [7:0] OFF_COMMAND = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int A3_MUX = 6;
  localparam int A3_GROUND = 5;
  localparam int A3_REFERENCE = 4;
  localparam int A3_OSCILLATOR = 3;
  localparam int F4_STACK_SUM = 0;
  localparam int BAT_SLEEP = 15;
  localparam int BAT_SHUTDOWN = 13;
  localparam int BAT_PF_SUMMARY = 12;
  localparam int BAT_SAFETY = 11;
  localparam int BAT_FUSE = 10;
  localparam int BAT_LEVEL_LO = 8;
  localparam int BAT_BLOCKED = 7;
  localparam int BAT_PENDING = 6;
  localparam int BAT_POWER_ON = 3;
  localparam int BAT_EDIT = 0;
  localparam int MASK_WIDTH = 9;

  // ----------------------------------------------------------------
  // Security levels and commands
  // ----------------------------------------------------------------
  localparam logic [1:0] LEVEL_UNINIT = 2'h0;
  localparam logic [1:0] LEVEL_UNRESTRICTED = 2'h1;
  localparam logic [1:0] LEVEL_PARTIAL = 2'h2;
  localparam logic [1:0] LEVEL_LOCKED = 2'h3;
  localparam logic [7:0] CMD_ENTER_EDIT = 8'h01;
  localparam logic [7:0] CMD_EXIT_EDIT = 8'h02;
  localparam logic [7:0] CMD_SHUTDOWN = 8'h03;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic RST_POWER_ON = 1'b1;
  localparam logic RST_BLOCKED = 1'b1;
  localparam logic [8:0] RST_ENABLE_MASK = 9'h1FF;
  localparam int unsigned ONE_SECOND_NS = 1000000000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SECOND_CYCLES_DEFAULT = ONE_SECOND_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic commanded;
    logic mux;
    logic ground;
    logic reference;
    logic oscillator;
    logic instrRom;
    logic dataRom;
    logic otpMem;
  } fault_third_t;

  typedef struct packed {
    logic muxAlert;
    logic groundAlert;
    logic referenceAlert;
    logic oscillatorAlert;
    fault_third_t faultThird;
    logic stackSumAlert;
    logic stackSumFault;
  } conditions_t;

  typedef struct packed {
    logic sleepActive;
    logic safetyFault;
    logic programmingOk;
    logic otpDataRequest;
    logic otpAllWritten;
  } device_state_t;

endpackage

// ### src/fault_battery_flags.sv
`timescale 1ns/1ps

// Overview of operation
// - Third alert: mux, ground, reference, oscillator bits
// - Third fault status: eight failure bits 7..0
// - Fourth alert/status: stack mismatch bit 0
// - Flags read one exactly while triggered
// - Bit 15 reads sleep state
// - Bit 13 set by command or pin
// - Bit 12: any enabled permanent fault
// - Bit 11: safety fault input, not masked
// - Bit 10: fuse pin sampled each second
// - Bits 9..8 report security level
// - Locked: config access refused, commands restricted
// - Partial: reads allowed, writes need edit
// - Unrestricted: config access and the three defined commands accepted
// - Bit 7 blocked; one when nothing pending outside edit mode
// - Blocked evaluated at edit entry, then held
// - Bit 6 pending until conditions and written
// - Pending never sets inside edit mode
// - Bit 0 set after enter command processed
// - Bit 3 set on reset, cleared at exit
module fault_battery_flags #(
  parameter int unsigned SECOND_CYCLES = fbs_pkg::SECOND_CYCLES_DEFAULT
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  input wire fbs_pkg::apb_req_t apbReq,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire fbs_pkg::conditions_t cond,
  input wire fbs_pkg::device_state_t devState,
  input wire logic [1:0] securityLevel,
  input wire logic fusePin,
  input wire logic shutdownPin,
  output logic editActive,
  output logic shutdownPending
);
  import fbs_pkg::*;

  logic [7:0] alertThird, statusThird, alertFourth, statusFourth;
  logic [7:0] next_alertThird, next_alertFourth, next_statusFourth;
  logic sleepFlag, pfSummary, safetySummary, fuseFlag, blocked, pending, powerOn;
  logic [1:0] levelFlag, fuseSync, shutSync;
  logic [MASK_WIDTH-1:0] enableMask;
  logic [26:0] secCount, holdCount;
  logic enterReq, exitReq, secTick, holdDone, access, done, wrDone, cmdWrite;
  logic cfgReadOk, cfgWriteOk, cmdOk, next_err;
  logic [15:0] batteryWord;
  logic [31:0] next_rdata;

  // ----------------------------------------------------------------
  // APB slave: one wait state, answer on the second access cycle
  // ----------------------------------------------------------------
  assign access = apbReq.psel && apbReq.penable;
  assign done = access && pready;
  assign wrDone = done && apbReq.pwrite;

  always_ff @(posedge clock) begin
    if (srst) begin
      pready <= 1'b0;
    end else if (ce) begin
      pready <= access && !pready;
    end
  end

  // Uninitialised level refuses config access and all commands until firmware sets a level
  assign cfgReadOk = (levelFlag == LEVEL_UNRESTRICTED) || (levelFlag == LEVEL_PARTIAL);
  assign cfgWriteOk = (levelFlag == LEVEL_UNRESTRICTED) ||
                      ((levelFlag == LEVEL_PARTIAL) && editActive);

  assign cmdOk = (cfgReadOk && (apbReq.pwdata[7:0] == CMD_ENTER_EDIT ||
                                apbReq.pwdata[7:0] == CMD_EXIT_EDIT)) ||
                 (levelFlag != LEVEL_UNINIT && apbReq.pwdata[7:0] == CMD_SHUTDOWN);
  assign cmdWrite = wrDone && apbReq.paddr == OFF_COMMAND && cmdOk;

  always_comb begin
    batteryWord = '0;
    batteryWord[BAT_SLEEP] = sleepFlag;
    batteryWord[BAT_SHUTDOWN] = shutdownPending;
    batteryWord[BAT_PF_SUMMARY] = pfSummary;
    batteryWord[BAT_SAFETY] = safetySummary;
    batteryWord[BAT_FUSE] = fuseFlag;
    batteryWord[BAT_LEVEL_LO +: 2] = levelFlag;
    batteryWord[BAT_BLOCKED] = blocked;
    batteryWord[BAT_PENDING] = pending;
    batteryWord[BAT_POWER_ON] = powerOn;
    batteryWord[BAT_EDIT] = editActive;
  end

  always_comb begin
    next_rdata = '0;
    // Flag registers are read-only; a write is refused and changes nothing
    next_err = apbReq.pwrite;
    if (apbReq.paddr[1:0] != 2'h0) begin
      next_err = 1'b1;
    end else begin
      case (apbReq.paddr)
        OFF_ALERT_THIRD: next_rdata = {24'h000000, alertThird};
        OFF_STATUS_THIRD: next_rdata = {24'h000000, statusThird};
        OFF_ALERT_FOURTH: next_rdata = {24'h000000, alertFourth};
        OFF_STATUS_FOURTH: next_rdata = {24'h000000, statusFourth};
        OFF_BATTERY: next_rdata = {16'h0000, batteryWord};
        OFF_CONFIG: begin
          next_err = apbReq.pwrite ? !cfgWriteOk : !cfgReadOk;
          next_rdata = cfgReadOk ? {23'h000000, enableMask} : 32'h00000000;
        end
        OFF_COMMAND: begin
          next_err = apbReq.pwrite && !cmdOk;
        end
        default: begin
          next_err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (ce) begin
      prdata <= (access && !pready && !apbReq.pwrite) ? next_rdata : 32'h00000000;
      pslverr <= access && !pready && next_err;
    end
  end

  // ----------------------------------------------------------------
  // Configuration and commands
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      enableMask <= RST_ENABLE_MASK;
    end else if (ce && wrDone && apbReq.paddr == OFF_CONFIG && cfgWriteOk) begin
      enableMask <= apbReq.pwdata[MASK_WIDTH-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      enterReq <= 1'b0;
      exitReq <= 1'b0;
    end else if (ce) begin
      enterReq <= cmdWrite && apbReq.pwdata[7:0] == CMD_ENTER_EDIT;
      exitReq <= cmdWrite && apbReq.pwdata[7:0] == CMD_EXIT_EDIT;
    end
  end

  // Edit mode opens two cycles after the cycle in which the command completes
  always_ff @(posedge clock) begin
    if (srst) begin
      editActive <= 1'b0;
    end else if (ce) begin
      if (enterReq) begin
        editActive <= 1'b1;
      end else if (exitReq) begin
        editActive <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      powerOn <= RST_POWER_ON;
    end else if (ce && exitReq && editActive) begin
      powerOn <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and one-second timing
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      fuseSync <= '0;
      shutSync <= '0;
    end else if (ce) begin
      fuseSync <= {fuseSync[0], fusePin};
      shutSync <= {shutSync[0], shutdownPin};
    end
  end

  assign secTick = secCount == 27'(SECOND_CYCLES - 1);
  assign holdDone = holdCount == 27'(SECOND_CYCLES - 1);

  always_ff @(posedge clock) begin
    if (srst) begin
      secCount <= '0;
    end else if (ce) begin
      secCount <= secTick ? 27'h0000000 : secCount + 27'h0000001;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      holdCount <= '0;
    end else if (ce) begin
      if (!shutSync[1]) begin
        holdCount <= '0;
      end else if (!holdDone) begin
        holdCount <= holdCount + 27'h0000001;
      end
    end
  end

  // Pending shutdown is final; only a reset clears it
  always_ff @(posedge clock) begin
    if (srst) begin
      shutdownPending <= 1'b0;
    end else if (ce) begin
      if ((cmdWrite && apbReq.pwdata[7:0] == CMD_SHUTDOWN) || holdDone) begin
        shutdownPending <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      fuseFlag <= 1'b0;
    end else if (ce && secTick) begin
      fuseFlag <= fuseSync[1];
    end
  end

  // ----------------------------------------------------------------
  // Fault and status flags
  // ----------------------------------------------------------------
  always_comb begin
    next_alertThird = '0;
    next_alertThird[A3_MUX] = cond.muxAlert;
    next_alertThird[A3_GROUND] = cond.groundAlert;
    next_alertThird[A3_REFERENCE] = cond.referenceAlert;
    next_alertThird[A3_OSCILLATOR] = cond.oscillatorAlert;
    next_alertFourth = '0;
    next_alertFourth[F4_STACK_SUM] = cond.stackSumAlert;
    next_statusFourth = '0;
    next_statusFourth[F4_STACK_SUM] = cond.stackSumFault;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      alertThird <= '0;
      statusThird <= '0;
      alertFourth <= '0;
      statusFourth <= '0;
    end else if (ce) begin
      alertThird <= next_alertThird;
      statusThird <= cond.faultThird;
      alertFourth <= next_alertFourth;
      statusFourth <= next_statusFourth;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      sleepFlag <= 1'b0;
      pfSummary <= 1'b0;
      safetySummary <= 1'b0;
      levelFlag <= LEVEL_UNINIT;
    end else if (ce) begin
      sleepFlag <= devState.sleepActive;
      pfSummary <= |({cond.stackSumFault, cond.faultThird} & enableMask);
      safetySummary <= devState.safetyFault;
      levelFlag <= securityLevel;
    end
  end

  // Outside edit mode the flag tracks live conditions; inside it is frozen
  always_ff @(posedge clock) begin
    if (srst) begin
      blocked <= RST_BLOCKED;
    end else if (ce) begin
      if (enterReq && !editActive) begin
        blocked <= !devState.programmingOk;
      end else if (!editActive) begin
        blocked <= pending ? !devState.programmingOk : 1'b1;
      end
    end
  end

  // Set wins over clear when both arrive together
  always_ff @(posedge clock) begin
    if (srst) begin
      pending <= 1'b0;
    end else if (ce) begin
      if (devState.otpDataRequest && !editActive) begin
        pending <= 1'b1;
      end else if (devState.programmingOk && devState.otpAllWritten) begin
        pending <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_alert_third;
    @(posedge clock) disable iff (srst)
    ce |=> alertThird == {1'b0, $past(cond.muxAlert), $past(cond.groundAlert),
                          $past(cond.referenceAlert), $past(cond.oscillatorAlert), 3'h0};
  endproperty
  a_alert_third: assert property (p_alert_third) else $error("third alert mismatch");

  property p_status_third;
    @(posedge clock) disable iff (srst)
    ce ##1 ce |=> statusThird == $past(cond.faultThird);
  endproperty
  a_status_third: assert property (p_status_third) else $error("third status mismatch");

  property p_fourth;
    @(posedge clock) disable iff (srst)
    ce |=> alertFourth == {7'h00, $past(cond.stackSumAlert)} &&
           statusFourth == {7'h00, $past(cond.stackSumFault)};
  endproperty
  a_fourth: assert property (p_fourth) else $error("fourth registers mismatch");

  property p_sleep;
    @(posedge clock) disable iff (srst)
    ce && devState.sleepActive |=> batteryWord[BAT_SLEEP];
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep bit not set");

  property p_hold_shutdown;
    @(posedge clock) disable iff (srst)
    ce && holdDone |=> shutdownPending;
  endproperty
  a_hold_shutdown: assert property (p_hold_shutdown) else $error("pin shutdown lost");

  property p_pf_summary;
    @(posedge clock) disable iff (srst)
    ce && cond.stackSumFault && enableMask[MASK_WIDTH-1] |=> pfSummary;
  endproperty
  a_pf_summary: assert property (p_pf_summary) else $error("summary not set");

  property p_fuse;
    @(posedge clock) disable iff (srst)
    ce && secTick |=> fuseFlag == $past(fuseSync[1]);
  endproperty
  a_fuse: assert property (p_fuse) else $error("fuse sample wrong");

  property p_locked_write;
    @(posedge clock) disable iff (srst)
    ce && wrDone && apbReq.paddr == OFF_CONFIG && levelFlag == LEVEL_LOCKED
      |-> pslverr ##1 $stable(enableMask);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("locked write taken");

  property p_blocked_idle;
    @(posedge clock) disable iff (srst)
    ce && !editActive && !enterReq && !pending |=> blocked;
  endproperty
  a_blocked_idle: assert property (p_blocked_idle) else $error("blocked clear");

  property p_blocked_hold;
    @(posedge clock) disable iff (srst)
    editActive && !enterReq |=> $stable(blocked);
  endproperty
  a_blocked_hold: assert property (p_blocked_hold) else $error("blocked moved in edit");

  property p_pending_edit;
    @(posedge clock) disable iff (srst)
    editActive && !pending |=> !pending;
  endproperty
  a_pending_edit: assert property (p_pending_edit) else $error("pending set in edit");

  property p_enter_edit;
    @(posedge clock) disable iff (srst)
    ce && cmdWrite && apbReq.pwdata[7:0] == CMD_ENTER_EDIT ##1 ce |=> editActive;
  endproperty
  a_enter_edit: assert property (p_enter_edit) else $error("edit not entered");

  property p_power_on;
    @(posedge clock) disable iff (srst)
    ce && exitReq && editActive |=> !powerOn && !editActive;
  endproperty
  a_power_on: assert property (p_power_on) else $error("power flag kept");

  property p_read_only;
    @(posedge clock) disable iff (srst)
    wrDone && apbReq.paddr == OFF_BATTERY |-> pslverr;
  endproperty
  a_read_only: assert property (p_read_only) else $error("status write accepted");

endmodule // fault_battery_flags

// ### verif/apb_host_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Host side of the register bus
// ----------------------------------------------------------------
module apb_host_model (
  input wire logic clock,
  output fbs_pkg::apb_req_t req,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  import fbs_pkg::*;

  initial begin
    req = '{psel: 1'b0, penable: 1'b0, pwrite: 1'b0, paddr: 8'h55, pwdata: 32'hA5A5_5A5A};
  end

  // Waits one edge first, so a release and a new setup never share a time step
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge clock);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
    @(posedge clock);
    req.penable <= 1'b1;
    // Only the bench watchdog ends a wait for the answer
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    // Released lines show the inverse so stale values cannot pass
    req <= '{psel: 1'b0, penable: 1'b0, pwrite: ~wr, paddr: ~addr, pwdata: ~wd};
  endtask
endmodule // apb_host_model

// ### verif/testbench.sv
`timescale 1ns/1ps

module testbench;
  import fbs_pkg::*;
  localparam int SEC = 16;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  apb_req_t apbReq;
  logic [31:0] prdata;
  logic pready, pslverr, editActive, shutdownPending;
  conditions_t cond = '0;
  device_state_t dev = '0;
  logic [1:0] secLvl = LEVEL_UNRESTRICTED;
  logic fusePin = 1'b0;
  logic shutdownPin = 1'b0;
  int error_cnt = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'hABE7;
  logic [31:0] v;
  logic sd = 0, fuse = 0, blk = 1, pend = 0, por = 1, edit = 0;
  logic [8:0] mask = 9'h1FF;

  fault_battery_flags #(.SECOND_CYCLES(SEC)) DUT (.clock(clock), .srst(srst), .ce(ce),
    .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cond(cond),
    .devState(dev), .securityLevel(secLvl), .fusePin(fusePin), .shutdownPin(shutdownPin),
    .editActive(editActive), .shutdownPending(shutdownPending));
  apb_host_model host (.clock(clock), .req(apbReq), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  initial forever #5 clock = ~clock;

  // ----------------------------------------------------------------
  // Expectations and helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
  endfunction

  function automatic logic [31:0] exp_reg(input logic [7:0] a);
    case (a)
      OFF_ALERT_THIRD: return {25'h0, cond.muxAlert, cond.groundAlert, cond.referenceAlert,
                               cond.oscillatorAlert, 3'h0};
      OFF_STATUS_THIRD: return {24'h0, cond.faultThird};
      OFF_ALERT_FOURTH: return {31'h0, cond.stackSumAlert};
      OFF_STATUS_FOURTH: return {31'h0, cond.stackSumFault};
      default: return {16'h0, dev.sleepActive, 1'b0, sd,
                       |({cond.stackSumFault, cond.faultThird} & mask), dev.safetyFault, fuse,
                       secLvl, blk, pend, 2'h0, por, 2'h0, edit};
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    tests_run++;
    if (got !== want) begin
      error_cnt++;
      $display("MISMATCH %0t got %h want %h", $time, got, want);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] want, input logic wantErr);
    logic [31:0] rd;
    logic err;
    host.xfer(1'b0, a, 32'h0, rd, err);
    chk({31'h0, err}, {31'h0, wantErr});
    chk(rd, want);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic wantErr);
    logic [31:0] rd;
    logic err;
    host.xfer(1'b1, a, d, rd, err);
    chk({31'h0, err}, {31'h0, wantErr});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic give_verdict;
    $display("errors %0d comparisons %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Run needs about 850 cycles
  initial begin
    #200000;
    error_cnt++;
    give_verdict;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    settle(2);
    srst <= 1'b0;
    settle(3);
    rd_chk(OFF_BATTERY, exp_reg(OFF_BATTERY), 1'b0);
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      v = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0 : seed;
      cond <= conditions_t'(v[13:0]);
      dev.sleepActive <= v[14];
      dev.safetyFault <= v[15];
      dev.programmingOk <= v[16];
      settle(3);
      for (int a = 0; a <= 16; a += 4) rd_chk(a, exp_reg(a), 1'b0);
    end
    for (int a = 0; a <= 16; a += 4) begin
      wr(a, 32'hFFFF_FFFF, 1'b1);
      rd_chk(a, exp_reg(a), 1'b0);
    end
    wr(8'h1C, 32'h0, 1'b1);
    rd_chk(8'h02, 32'h0, 1'b1);
    cond <= conditions_t'(14'h0001);
    wr(OFF_CONFIG, 32'h0FF, 1'b0);
    mask = 9'h0FF;
    settle(3);
    rd_chk(OFF_BATTERY, exp_reg(OFF_BATTERY), 1'b0);
    rd_chk(OFF_CONFIG, 32'h0FF, 1'b0);
    wr(OFF_CONFIG, 32'h1FF, 1'b0);
    mask = 9'h1FF;
    secLvl <= LEVEL_LOCKED;
    settle(3);
    rd_chk(OFF_CONFIG, 32'h0, 1'b1);
    wr(OFF_CONFIG, 32'h1FF, 1'b1);
    wr(OFF_COMMAND, {24'h0, CMD_ENTER_EDIT}, 1'b1);
    rd_chk(OFF_BATTERY, exp_reg(OFF_BATTERY), 1'b0);
    secLvl <= LEVEL_PARTIAL;
    dev.programmingOk <= 1'b1;
    settle(3);
    rd_chk(OFF_CONFIG, 32'h1FF, 1'b0);
    wr(OFF_CONFIG, 32'h1FF, 1'b1);
    wr(OFF_COMMAND, {24'h0, CMD_ENTER_EDIT}, 1'b0);
    settle(4);
    edit = 1;
    blk = 0;
    chk({31'h0, editActive}, 32'h1);
    // Conditions go bad inside edit mode; blocked must not follow
    dev.programmingOk <= 1'b0;
    dev.otpDataRequest <= 1'b1;
    settle(4);
    rd_chk(OFF_BATTERY, exp_reg(OFF_BATTERY), 1'b0);
    wr(OFF_CONFIG, 32'h1FF, 1'b0);
    wr(OFF_COMMAND, {24'h0, CMD_EXIT_EDIT}, 1'b0);
    settle(4);
    edit = 0;
    por = 0;
    pend = 1;
    // Pending data with bad conditions keeps writes blocked
    blk = 1;
    rd_chk(OFF_BATTERY, exp_reg(OFF_BATTERY), 1'b0);
    dev.programmingOk <= 1'b1;
    dev.otpDataRequest <= 1'b0;
    settle(4);
    blk = 0;
    rd_chk(OFF_BATTERY, exp_reg(OFF_BATTERY), 1'b0);
    dev.otpAllWritten <= 1'b1;
    settle(4);
    pend = 0;
    blk = 1;
    rd_chk(OFF_BATTERY, exp_reg(OFF_BATTERY), 1'b0);
    fusePin <= 1'b1;
    settle(2 * SEC + 6);
    fuse = 1;
    rd_chk(OFF_BATTERY, exp_reg(OFF_BATTERY), 1'b0);
    fusePin <= 1'b0;
    settle(2 * SEC + 6);
    fuse = 0;
    rd_chk(OFF_BATTERY, exp_reg(OFF_BATTERY), 1'b0);
    shutdownPin <= 1'b1;
    settle(SEC / 2);
    shutdownPin <= 1'b0;
    settle(4);
    chk({31'h0, shutdownPending}, 32'h0);
    shutdownPin <= 1'b1;
    settle(SEC + 8);
    shutdownPin <= 1'b0;
    sd = 1;
    chk({31'h0, shutdownPending}, 32'h1);
    rd_chk(OFF_BATTERY, exp_reg(OFF_BATTERY), 1'b0);
    secLvl <= LEVEL_UNRESTRICTED;
    srst <= 1'b1;
    settle(2);
    srst <= 1'b0;
    sd = 0;
    por = 1;
    settle(3);
    rd_chk(OFF_BATTERY, exp_reg(OFF_BATTERY), 1'b0);
    wr(OFF_COMMAND, {24'h0, CMD_SHUTDOWN}, 1'b0);
    settle(2);
    chk({31'h0, shutdownPending}, 32'h1);
    wr(OFF_COMMAND, 32'h7E, 1'b1);
    give_verdict;
  end
endmodule // testbench
